// ===== rtl/cable_port_sideband.v
// Purpose: sideband control of cable ports and the aux digital connector
//          behind a classic Wishbone register slave
// Assumes: one free-running clock, synchronous active-high reset,
//          up to eight cable ports, aux width up to 32
// Notes:   all pin inputs pass a two-stage synchroniser; every output
//          comes from a flip-flop, so aux and management pins follow register
//          writes at the same edge that raises the acknowledge
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "cable_port_sideband_regs.vh"

module cable_port_sideband
#(
    parameter NUM_PORTS = 2,  // number of cable ports, at most 8
    parameter AUX_WIDTH = 20  // aux digital lines, at most 32
)
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // interrupt
    output reg irq_o,
    // management data lines, open drain
    input wire [NUM_PORTS-1:0] module_def_line_two_i,
    output reg [NUM_PORTS-1:0] module_def_line_two_o,
    output reg [NUM_PORTS-1:0] module_def_line_two_oe_o,
    // presence detect pin shared with sideband output
    input wire [NUM_PORTS-1:0] cable_present_n_i,
    output reg [NUM_PORTS-1:0] cable_sideband_out_o,
    output reg [NUM_PORTS-1:0] cable_sideband_drive_en_n_o,
    // cable power
    output reg [NUM_PORTS-1:0] cable_power_en_o,
    input wire [NUM_PORTS-1:0] cable_power_ok_i,
    // aux digital connector
    input wire [AUX_WIDTH-1:0] aux_dio_in_i,
    output reg [AUX_WIDTH-1:0] aux_dio_out_o,
    output reg [AUX_WIDTH-1:0] aux_dio_drive_en_n_o
);

    // merge write data into a word under the byte enables
    function [31:0] merge_bytes;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0] sel;
        integer b;
        begin
            merge_bytes = old_word;
            for (b = 0; b < 4; b = b + 1)
            begin
                if (sel[b])
                begin
                    merge_bytes[b*8 +: 8] = new_word[b*8 +: 8];
                end
            end
        end
    endfunction

    // synchroniser stages; first stages are read only by the second
    reg [NUM_PORTS-1:0] present_meta; // presence, stage one
    reg [NUM_PORTS-1:0] present_n_sync; // presence, stage two
    reg [NUM_PORTS-1:0] ok_meta; // power good, stage one
    reg [NUM_PORTS-1:0] ok_sync; // power good, stage two
    reg [NUM_PORTS-1:0] ok_prev; // power good, one cycle older
    reg [NUM_PORTS-1:0] mgmt_meta; // management data, stage one
    reg [NUM_PORTS-1:0] mgmt_sync; // management data, stage two
    reg [AUX_WIDTH-1:0] aux_meta; // aux inputs, stage one
    reg [AUX_WIDTH-1:0] aux_sync; // aux inputs, stage two
    reg [NUM_PORTS-1:0] present_prev; // presence seen last cycle

    // software visible state, plus the fault latch, which no register reads back
    reg [31:0] ctrl; // power requests and management pull-low bits
    reg [31:0] irq_status; // sticky event bits
    reg [31:0] irq_mask; // interrupt enables, same layout
    reg [NUM_PORTS-1:0] fault; // latched supply fault per port

    // decoded and derived terms
    wire bus_req; // valid request not yet answered
    wire bus_wr; // write taken this cycle
    wire [NUM_PORTS-1:0] present; // cable inserted, active high
    wire [NUM_PORTS-1:0] power_req; // software asks for power
    wire [NUM_PORTS-1:0] mgmt_low; // software pulls data line low
    reg [NUM_PORTS-1:0] next_power_en; // power enable for next cycle
    reg [NUM_PORTS-1:0] fault_event; // supply dropped while enabled
    reg [NUM_PORTS-1:0] presence_event; // insertion or removal
    reg [31:0] irq_set; // events raised this cycle
    reg [31:0] irq_clear; // ones written to the status register
    reg [31:0] next_ctrl; // ctrl after a write
    reg [31:0] status_word; // live status for reads
    reg [31:0] read_word; // read mux output
    reg [31:0] aux_out_word; // aux value word after a byte merge
    reg [31:0] aux_drive_word; // aux enable word after a byte merge
    localparam [31:0] aux_out_rst = `RST_AUX_OUT; // cut to width when used
    localparam [31:0] aux_drive_rst = `RST_AUX_DRIVE_N; // released
    integer p;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;

    // presence pin is low while a connector is inserted
    assign present = ~present_n_sync;
    assign power_req = ctrl[`CTRL_POWER_REQ_LSB +: NUM_PORTS];
    assign mgmt_low = ctrl[`CTRL_MGMT_LOW_LSB +: NUM_PORTS];

    // input synchronisers; nothing decides on a pin before stage two
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // all stages start as no cable, no power, idle lines
            present_meta <= {NUM_PORTS{1'b1}};
            present_n_sync <= {NUM_PORTS{1'b1}};
            ok_meta <= {NUM_PORTS{1'b0}};
            ok_sync <= {NUM_PORTS{1'b0}};
            mgmt_meta <= {NUM_PORTS{1'b1}};
            mgmt_sync <= {NUM_PORTS{1'b1}};
            aux_meta <= {AUX_WIDTH{1'b0}};
            aux_sync <= {AUX_WIDTH{1'b0}};
        end
        else
        begin
            present_meta <= cable_present_n_i;
            present_n_sync <= present_meta;
            ok_meta <= cable_power_ok_i;
            ok_sync <= ok_meta;
            mgmt_meta <= module_def_line_two_i;
            mgmt_sync <= mgmt_meta;
            aux_meta <= aux_dio_in_i;
            aux_sync <= aux_meta;
        end
    end

    // history flops used for edge detection, fed from stage two only
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ok_prev <= {NUM_PORTS{1'b0}};
            present_prev <= {NUM_PORTS{1'b0}};
        end
        else
        begin
            ok_prev <= ok_sync;
            present_prev <= present;
        end
    end

    // event detection and power enable decision
    always @*
    begin
        fault_event = {NUM_PORTS{1'b0}};
        presence_event = {NUM_PORTS{1'b0}};
        next_power_en = {NUM_PORTS{1'b0}};
        for (p = 0; p < NUM_PORTS; p = p + 1)
        begin
            // power good fell while we still drive the enable
            fault_event[p] = cable_power_en_o[p] & ok_prev[p] & ~ok_sync[p];
            presence_event[p] = present[p] ^ present_prev[p];
            // no cable or a latched fault forces the supply off
            next_power_en[p] = power_req[p] & present[p] & ~fault[p]
                & ~fault_event[p];
        end
    end

    // supply fault latch; a fault holds power off until software
    // drops the request, which avoids cycling into an overload
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault <= {NUM_PORTS{1'b0}};
        end
        else
        begin
            // an event sets, a withdrawn request rearms; set wins
            fault <= fault_event | (fault & power_req);
        end
    end

    // power enable flops; supply is expected to report ok while on
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cable_power_en_o <= {NUM_PORTS{1'b0}};
        end
        else
        begin
            cable_power_en_o <= next_power_en;
        end
    end

    // write data merged under byte enables
    always @*
    begin
        aux_out_word = merge_bytes({{(32-AUX_WIDTH){1'b0}}, aux_dio_out_o},
            wb_dat_i, wb_sel_i);
        aux_drive_word = merge_bytes({{(32-AUX_WIDTH){1'b1}},
            aux_dio_drive_en_n_o}, wb_dat_i, wb_sel_i);
        next_ctrl = ctrl;
        if (bus_wr && wb_adr_i == `OFS_CTRL)
        begin
            next_ctrl = merge_bytes(ctrl, wb_dat_i, wb_sel_i);
        end
    end

    // writable registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= `RST_CTRL;
            irq_mask <= `RST_IRQ_MASK;
        end
        else
        begin
            ctrl <= next_ctrl;
            if (bus_wr && wb_adr_i == `OFS_IRQ_MASK)
            begin
                irq_mask <= merge_bytes(irq_mask, wb_dat_i, wb_sel_i);
            end
        end
    end

    // event set and write-one-to-clear terms
    always @*
    begin
        irq_set = 32'h0000_0000;
        irq_clear = 32'h0000_0000;
        irq_set[`IRQ_PRESENCE_LSB +: NUM_PORTS] = presence_event;
        irq_set[`IRQ_FAULT_LSB +: NUM_PORTS] = fault_event;
        if (bus_wr && wb_adr_i == `OFS_IRQ_STATUS)
        begin
            irq_clear = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_status <= 32'h0000_0000;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
        end
    end

    // level interrupt from any unmasked status bit
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(((irq_status & ~irq_clear) | irq_set) & irq_mask);
        end
    end

    // open-drain management line: output value is tied low, only the
    // enable moves, so the line is never driven high
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            module_def_line_two_o <= {NUM_PORTS{1'b0}};
            module_def_line_two_oe_o <= {NUM_PORTS{1'b0}};
        end
        else
        begin
            module_def_line_two_o <= {NUM_PORTS{1'b0}};
            module_def_line_two_oe_o <= next_ctrl[`CTRL_MGMT_LOW_LSB +:
                NUM_PORTS];
        end
    end

    // sideband driver stays off so the pin works as presence detect
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cable_sideband_drive_en_n_o <= {NUM_PORTS{1'b1}};
            cable_sideband_out_o <= {NUM_PORTS{1'b0}};
        end
        else
        begin
            cable_sideband_drive_en_n_o <= {NUM_PORTS{1'b1}};
            cable_sideband_out_o <= {NUM_PORTS{1'b0}}; // unused output
        end
    end

    // aux outputs: value and per-bit active-low enable registers;
    // the pad only shows a value bit while its enable is low
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            aux_dio_out_o <= aux_out_rst[AUX_WIDTH-1:0];
            aux_dio_drive_en_n_o <= aux_drive_rst[AUX_WIDTH-1:0];
        end
        else if (bus_wr)
        begin
            if (wb_adr_i == `OFS_AUX_OUT)
            begin
                aux_dio_out_o <= aux_out_word[AUX_WIDTH-1:0];
            end
            if (wb_adr_i == `OFS_AUX_DRIVE_N)
            begin
                aux_dio_drive_en_n_o <= aux_drive_word[AUX_WIDTH-1:0];
            end
        end
    end

    // live status word assembled from synchronised inputs and the power enables
    always @*
    begin
        status_word = 32'h0000_0000;
        status_word[`STAT_PRESENT_LSB +: NUM_PORTS] = present;
        status_word[`STAT_POWER_OK_LSB +: NUM_PORTS] = ok_sync;
        status_word[`STAT_POWER_EN_LSB +: NUM_PORTS] = cable_power_en_o;
        status_word[`STAT_MGMT_IN_LSB +: NUM_PORTS] = mgmt_sync;
    end

    // read mux; unmapped offsets read as zero but are still answered
    always @*
    begin
        read_word = 32'h0000_0000;
        case (wb_adr_i)
            `OFS_CTRL: read_word = ctrl;
            `OFS_STATUS: read_word = status_word;
            `OFS_IRQ_STATUS: read_word = irq_status;
            `OFS_IRQ_MASK: read_word = irq_mask;
            `OFS_AUX_OUT: read_word[AUX_WIDTH-1:0] = aux_dio_out_o;
            `OFS_AUX_DRIVE_N: read_word[AUX_WIDTH-1:0] =
                aux_dio_drive_en_n_o;
            `OFS_AUX_IN: read_word[AUX_WIDTH-1:0] = aux_sync;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // bus answer: ack one cycle after the request, dropped next cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                wb_dat_o <= read_word; // sampled with the request
            end
        end
    end

endmodule // cable_port_sideband

// ===== rtl/cable_port_sideband_regs.vh
// Purpose: register offsets, field positions and reset values for the
//          cable port sideband block
// Assumes: 32-bit classic Wishbone slave, byte addresses, one word each
// Notes:   definitions only, no logic
//
// What this block does
// - management data line: pull low or release only
// - presence input is active low, low means present
// - sideband drive enable held at constant one
// - active-high cable power enable per port
// - power good dropping while enabled is fault
// - per-bit active-low aux drive enables
// - synchronised AUX_WIDTH-bit aux input vector (20 by default) for monitoring
// - aux output value appears only when enabled
// - single continuously running clock times everything
// - everything held in reset while reset high
`ifndef CABLE_PORT_SIDEBAND_REGS_VH
`define CABLE_PORT_SIDEBAND_REGS_VH

// word offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0c
`define OFS_AUX_OUT 8'h10
`define OFS_AUX_DRIVE_N 8'h14
`define OFS_AUX_IN 8'h18

// field positions: ctrl
`define CTRL_POWER_REQ_LSB 0
`define CTRL_MGMT_LOW_LSB 8
// field positions: status
`define STAT_PRESENT_LSB 0
`define STAT_POWER_OK_LSB 8
`define STAT_POWER_EN_LSB 16
`define STAT_MGMT_IN_LSB 24
// field positions: interrupt status and mask
`define IRQ_PRESENCE_LSB 0
`define IRQ_FAULT_LSB 8

// reset values
`define RST_CTRL 32'h0000_0000
`define RST_IRQ_MASK 32'h0000_0000
`define RST_AUX_OUT 32'h0000_0000
`define RST_AUX_DRIVE_N 32'hffff_ffff

`endif

// ===== testbench/cable_port_sideband_monitor.sv
// Purpose: port-level checker for the cable sideband block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design top, watches its ports only
`timescale 1ns/1ns
module sideband_monitor
#(
    parameter NUM_PORTS = 2,
    parameter AUX_WIDTH = 20
)
(
    // clock, reset and bus
    input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire irq_o,
    // cable side pins
    input wire [NUM_PORTS-1:0] module_def_line_two_o,
    input wire [NUM_PORTS-1:0] module_def_line_two_oe_o,
    input wire [NUM_PORTS-1:0] cable_present_n_i,
    input wire [NUM_PORTS-1:0] cable_sideband_drive_en_n_o,
    input wire [NUM_PORTS-1:0] cable_power_en_o,
    input wire [NUM_PORTS-1:0] cable_power_ok_i,
    // aux pins
    input wire [AUX_WIDTH-1:0] aux_dio_out_o,
    input wire [AUX_WIDTH-1:0] aux_dio_drive_en_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a full-word write taken at this edge
    wire wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_sel_i == 4'hf;

    AST_MGMT_LOW_ONLY: assert property (module_def_line_two_o == 0)
        else $error("mgmt data driven high");
    AST_MGMT_OE: assert property (wr_go && wb_adr_i == 8'h00 |=>
        module_def_line_two_oe_o == $past(wb_dat_i[8 +: NUM_PORTS]))
        else $error("mgmt pull-low not from ctrl write");
    AST_SIDEBAND_OFF: assert property (&cable_sideband_drive_en_n_o)
        else $error("sideband driver enabled");
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_RESET_VALUES: assert property ($fell(rst_i) |->
        cable_power_en_o == 0 && !irq_o && aux_dio_out_o == 0
        && &aux_dio_drive_en_n_o && module_def_line_two_oe_o == 0)
        else $error("outputs not at reset values");
    AST_NO_CABLE_NO_POWER: assert property (cable_present_n_i[0] [*4]
        |-> !cable_power_en_o[0]) else $error("power without cable");
    AST_FAULT_OFF: assert property (
        (cable_power_en_o[0] && cable_power_ok_i[0]) [*3] ##1
        (cable_power_en_o[0] && !cable_power_ok_i[0])
        |-> ##[1:5] !cable_power_en_o[0]) else $error("fault kept power");
    AST_AUX_DRIVE: assert property (wr_go && wb_adr_i == 8'h14 |=>
        aux_dio_drive_en_n_o == $past(wb_dat_i[AUX_WIDTH-1:0]))
        else $error("aux drive enables not written");
    AST_AUX_OUT: assert property (wr_go && wb_adr_i == 8'h10 |=>
        aux_dio_out_o == $past(wb_dat_i[AUX_WIDTH-1:0]))
        else $error("aux outputs not written");
    // main scenarios reached
    COV_FAULT: cover property (cable_power_en_o[0] ##1 !cable_power_en_o[0]);
    COV_IRQ: cover property ($rose(irq_o));
    COV_PULL_LOW: cover property (module_def_line_two_oe_o[0]);
endmodule // sideband_monitor

bind cable_port_sideband sideband_monitor #(.NUM_PORTS(NUM_PORTS),
    .AUX_WIDTH(AUX_WIDTH)) i_sideband_monitor (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .irq_o(irq_o),
    .module_def_line_two_o(module_def_line_two_o),
    .module_def_line_two_oe_o(module_def_line_two_oe_o),
    .cable_present_n_i(cable_present_n_i),
    .cable_sideband_drive_en_n_o(cable_sideband_drive_en_n_o),
    .cable_power_en_o(cable_power_en_o),
    .cable_power_ok_i(cable_power_ok_i), .aux_dio_out_o(aux_dio_out_o),
    .aux_dio_drive_en_n_o(aux_dio_drive_en_n_o));

// ===== testbench/cable_far_side.sv
// Purpose: model of the cable modules and the aux connector lines
// Assumes: one clock; the bench commands insertion and overload
// Notes:   power good follows the enable one cycle late
`timescale 1ns/1ns
module cable_far_side
(
    // clock and bench commands
    input wire clk_i,
    input wire [1:0] inserted_i,
    input wire [1:0] overload_i,
    input wire [19:0] ext_i,
    // from the block
    input wire [1:0] power_en_i,
    input wire [1:0] mgmt_out_i,
    input wire [1:0] mgmt_oe_i,
    input wire [19:0] aux_out_i,
    input wire [19:0] aux_en_n_i,
    // to the block
    output wire [1:0] present_n_o,
    output reg [1:0] power_ok_o = 2'b00,
    output wire [1:0] mgmt_line_o,
    output wire [19:0] aux_line_o
);
    // plug holds its pin low while inserted
    assign present_n_o = ~inserted_i;
    // pull-up wins unless the block pulls low
    assign mgmt_line_o = ~(mgmt_oe_i & ~mgmt_out_i);
    // released bits show the outside driver, never a stale value
    assign aux_line_o = (aux_out_i & ~aux_en_n_i) | (ext_i & aux_en_n_i);
    // supply good while enabled, lost on overload
    always @(posedge clk_i)
        power_ok_o <= power_en_i & ~overload_i;
endmodule // cable_far_side

// ===== testbench/cable_port_sideband_tb_top.sv
// Purpose: self-checking bench for the cable sideband block
// Assumes: 10 MHz clock, reset held ten cycles
// Notes:   expectations computed from integers in the bench
`timescale 1ns/1ns
module cable_port_sideband_tb_top;
    reg clk_i, rst_i, cyc, stb, we;
    reg [7:0] adr;
    reg [3:0] sel;
    reg [31:0] dat_w, rd, r1, r2, seed;
    reg [1:0] inserted, overload;
    reg [19:0] ext;
    wire [31:0] dat_r;
    wire ack, irq;
    wire [1:0] mg_in, mg_o, mg_oe, pres_n, sb_o, sb_en_n, pwr_en, pwr_ok;
    wire [19:0] aux_in, aux_o, aux_en_n;
    int miscompares, check_count, i;

    cable_port_sideband i_cable_port_sideband (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .irq_o(irq), .module_def_line_two_i(mg_in),
        .module_def_line_two_o(mg_o), .module_def_line_two_oe_o(mg_oe),
        .cable_present_n_i(pres_n), .cable_sideband_out_o(sb_o),
        .cable_sideband_drive_en_n_o(sb_en_n), .cable_power_en_o(pwr_en),
        .cable_power_ok_i(pwr_ok), .aux_dio_in_i(aux_in),
        .aux_dio_out_o(aux_o), .aux_dio_drive_en_n_o(aux_en_n));
    cable_far_side i_cable_far_side (.clk_i(clk_i), .inserted_i(inserted),
        .overload_i(overload), .ext_i(ext), .power_en_i(pwr_en),
        .mgmt_out_i(mg_o), .mgmt_oe_i(mg_oe), .aux_out_i(aux_o),
        .aux_en_n_i(aux_en_n), .present_n_o(pres_n), .power_ok_o(pwr_ok),
        .mgmt_line_o(mg_in), .aux_line_o(aux_in));

    initial
    begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end

    // xorshift source for random words
    function automatic [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; the wait for ack is bounded
    task wb(input [7:0] a, input w, input [31:0] d);
        int n;
        begin
            @(posedge clk_i);
            {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hf, d};
            n = 0;
            do
            begin
                @(posedge clk_i);
                n++;
            end
            while (ack !== 1'b1 && n < 50);
            if (ack !== 1'b1)
            begin
                chk("wb_ack_o", 1, ack);
                print_verdict;
            end
            // ack and read data taken at the edge that samples ack high
            rd = dat_r;
            {cyc, stb} <= 2'b00;
        end
    endtask

    task rdchk(input [7:0] a, input [31:0] e, input string nm);
        wb(a, 0, 0);
        chk(nm, e, rd);
    endtask

    task idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    initial
    begin
        {rst_i, cyc, stb, we, adr, sel, dat_w} = {1'b1, 47'h0};
        {inserted, overload, ext, seed} = {24'h0, 32'h5b85};
        {miscompares, check_count} = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        rdchk(8'h00, 0, "ctrl");
        rdchk(8'h0c, 0, "irq_mask");
        rdchk(8'h10, 0, "aux_out");
        rdchk(8'h14, 32'hfffff, "aux_drive_n");
        rdchk(8'h04, 32'h0300_0000, "status");
        chk("sideband_drive_en_n", 3, sb_en_n);
        chk("sideband_out", 0, sb_o);
        chk("mgmt_out", 0, mg_o);
        wb(8'h1c, 1, 32'hffff_ffff);
        rdchk(8'h1c, 0, "unmapped");
        $display("test reset done");
        for (i = 0; i < 5; i++)
        begin
            seed = xs(seed);
            r1 = seed;
            seed = xs(seed);
            r2 = (i == 0) ? 0 : seed;
            @(posedge clk_i) ext <= r1[31:12] ^ seed[19:0];
            wb(8'h10, 1, r1 & 32'hfffff);
            wb(8'h14, 1, r2 & 32'hfffff);
            idle(1);
            chk("aux_out_pins", r1[19:0], aux_o);
            chk("aux_drive_pins", r2[19:0], aux_en_n);
            idle(3);
            rd = (r1 & ~r2) | (ext & r2);
            rdchk(8'h18, rd[19:0], "aux_in");
        end
        $display("test aux done");
        @(posedge clk_i) inserted <= 2'b01;
        idle(5);
        rdchk(8'h04, 32'h0300_0001, "status");
        rdchk(8'h08, 1, "irq_status");
        chk("irq_masked", 0, irq);
        wb(8'h0c, 1, 32'h101);
        idle(1);
        chk("irq", 1, irq);
        wb(8'h08, 1, 1);
        idle(2);
        chk("irq_cleared", 0, irq);
        wb(8'h00, 1, 3);
        idle(5);
        chk("power_en", 1, pwr_en);
        rdchk(8'h04, 32'h0301_0101, "status");
        wb(8'h00, 1, 32'h103);
        idle(1);
        chk("mgmt_oe", 1, mg_oe);
        idle(3);
        rdchk(8'h04, 32'h0201_0101, "status_pulled");
        wb(8'h00, 1, 3);
        $display("test presence and power done");
        @(posedge clk_i) overload <= 2'b01;
        idle(6);
        chk("power_fault", 0, pwr_en);
        rdchk(8'h08, 32'h100, "irq_fault");
        chk("irq_fault_pin", 1, irq);
        wb(8'h08, 1, 32'h100);
        overload <= 0;
        wb(8'h00, 1, 0);
        wb(8'h00, 1, 3);
        idle(5);
        chk("power_back", 1, pwr_en);
        $display("test fault done");
        @(posedge clk_i) inserted <= 0;
        idle(5);
        chk("power_removed", 0, pwr_en);
        rdchk(8'h08, 1, "irq_removed");
        @(posedge clk_i) inserted <= 2'b01;
        idle(6);
        chk("power_reinsert", 1, pwr_en);
        $display("test removal done");
        print_verdict;
    end
endmodule // cable_port_sideband_tb_top
